// >>> design/ext_ctl_io_and_logic_ops.sv
// Execute unit for external-control load/store, I/O barrier, sign extends and xnor.
// Assumes a core that issues one decoded word with operands read, and a memory
// system that reports outstanding cache-inhibited accesses.
//
// How it works
// - Location is index alone when base field zero
// - Load-in sends uncached load, writes returned word
// - Store-out sends uncached store with source data
// - Protection sees load-in as load, store-out store
// - Barrier waits until earlier cache-inhibited accesses complete
// - Barrier only waits on cache-inhibited accesses
// - Barrier leaves condition field and exceptions alone
// - Word extend records flags when record set; carry marked affected
// - Word extend illegal on 32-bit implementations
// - Xnor writes complement of source xor index
// - Byte extend records flags when record set
//
// Chosen here: the strobed register access.
`timescale 1ns/1ps
`include "xops_defs.svh"
module ext_ctl_io_and_logic_ops #(
	parameter int XLEN = 64                          // Implementation width, 32 or 64
) (
	input  wire logic                 clock,
	input  wire logic                 reset,
	input  wire logic                 clock_enable,
	input  wire logic                 issue_valid,     // Instruction offered
	input  wire logic [31:0]          instr_word,      // Raw instruction
	input  wire logic [XLEN-1:0]      base_val,        // Base GPR contents
	input  wire logic [XLEN-1:0]      index_val,       // Index GPR contents
	input  wire logic [XLEN-1:0]      store_src_val,   // Source GPR contents
	input  wire logic                 xtrnl_accss_flag,// External access enable
	input  wire logic [5:0]           target_unit_id,  // Controller identifier
	input  wire logic                 summary_ovf,     // Exception summary overflow
	input  wire logic [XLEN-1:0]      real_addr_in,    // Translated address from MMU
	input  wire logic                 ext_ack,         // Controller finished
	input  wire logic [31:0]          ext_rdata,       // Controller returned word
	input  wire logic                 ci_pending,      // Earlier cache-inhibited access open
	input  wire logic                 irq_clear_wr,    // Write-one-to-clear strobe
	input  wire logic [2:0]           irq_clear_data,  // Bits to clear
	input  wire logic                 irq_mask_wr,     // Mask write strobe
	input  wire logic [2:0]           irq_mask_data,   // New mask
	output logic                      issue_ready,     // Unit idle
	output logic [XLEN-1:0]           eff_loc,         // Location to translate
	output logic                      prot_is_store,   // Protection access kind
	output logic                      ext_req,         // Controller request
	output logic                      ext_we,          // Store request
	output logic                      ext_uncached,    // Bypass cache
	output logic [XLEN-1:0]           ext_addr,        // Real address out
	output logic [5:0]                ext_id,          // Controller selected
	output logic [XLEN-1:0]           ext_wdata,       // Store data
	output logic                      mem_hold,        // Stall later accesses
	output logic                      wb_en,           // GPR write pulse
	output xops_pkg::gpr_idx_t        wb_idx,          // GPR written
	output logic [XLEN-1:0]           wb_data,         // Value written
	output logic                      cr0_we,          // Condition field write pulse
	output logic [3:0]                cr0_val,         // Negative, positive, zero, sticky
	output logic                      carry_we,        // Carry marked affected
	output logic                      illegal_exc,     // Illegal-instruction pulse
	output logic [2:0]                irq_status,      // Sticky events
	output logic                      irq              // Level interrupt
);
	import xops_pkg::*;

	initial begin
		if (XLEN != 32 && XLEN != 64) $error("XLEN must be 32 or 64");
	end

	// Field extraction, big-endian numbering mapped onto [31:0]
	wire logic [5:0]  opc     = instr_word[`OPC_MSB:`OPC_LSB];
	wire gpr_idx_t    rt_f    = instr_word[`RT_MSB:`RT_LSB];
	wire gpr_idx_t    ra_f    = instr_word[`RA_MSB:`RA_LSB];
	wire logic [9:0]  xo      = instr_word[`XO_MSB:`XO_LSB];
	wire logic        rc      = instr_word[`RC_POS];
	wire logic        prim_ok = (opc == `PRIMARY_OP);

	// Decoded instructions
	wire logic is_in    = prim_ok && xo == `XO_EXT_IN;
	wire logic is_out   = prim_ok && xo == `XO_EXT_OUT;
	wire logic is_bar   = prim_ok && xo == `XO_BARRIER;
	wire logic is_sw    = prim_ok && xo == `XO_SEXT_WORD;
	wire logic is_xnor  = prim_ok && xo == `XO_XNOR;
	wire logic is_sb    = prim_ok && xo == `XO_SEXT_BYTE;
	wire logic sw_legal = (XLEN == 64);

	// Location: index alone when base field is zero
	wire logic [XLEN-1:0] loc = (ra_f == 5'h00) ? index_val : base_val + index_val;

	// Results of the arithmetic instructions
	wire logic [XLEN-1:0] xnor_res = ~(store_src_val ^ index_val);
	wire logic [XLEN-1:0] sb_res   = {{(XLEN-8){store_src_val[7]}}, store_src_val[7:0]};
	wire logic [XLEN-1:0] sw_res   = {{(XLEN-32){store_src_val[31]}}, store_src_val[31:0]};
	wire logic [XLEN-1:0] alu_res  = is_xnor ? xnor_res : (is_sb ? sb_res : sw_res);

	// Signed compare with zero plus sticky copy
	function automatic logic [3:0] cr_flags(input logic [XLEN-1:0] r, input logic so);
		logic neg;
		logic zer;
		neg = r[XLEN-1];
		zer = (r == '0);
		return {neg, ~neg & ~zer, zer, so};
	endfunction : cr_flags

	exec_state_t          state_reg;
	exec_state_t          state_next;
	logic                 is_store_reg;                          // Pending op is store-out
	gpr_idx_t             dest_reg;                              // Destination of load-in

	wire logic take      = clock_enable && issue_valid && state_reg == ST_IDLE;
	wire logic alu_take  = take && (is_xnor || is_sb || (is_sw && sw_legal));
	wire logic ext_take  = take && (is_in || is_out) && xtrnl_accss_flag;
	wire logic bar_take  = take && is_bar;
	wire logic ill_take  = take && (is_sw && !sw_legal);
	wire logic bar_done  = state_reg == ST_DRAIN && !ci_pending;
	wire logic ext_done  = state_reg == ST_EXT && ext_ack;
	wire logic [2:0] evt = {ill_take, bar_done, ext_done};

	// Sequencer for external access and barrier
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (ext_take) state_next = ST_EXT;
				else if (bar_take) state_next = ST_DRAIN;
			end
			ST_EXT: begin
				if (ext_ack) state_next = ST_DONE;
			end
			ST_DRAIN: begin
				if (!ci_pending) state_next = ST_DONE;
			end
			ST_DONE: state_next = ST_IDLE;
			default: state_next = ST_IDLE;
		endcase
	end

	// State and captured operands
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			state_reg    <= ST_IDLE;
			is_store_reg <= 1'b0;
			dest_reg     <= '0;
		end else if (clock_enable) begin
			state_reg <= state_next;
			if (take) begin
				is_store_reg <= is_out;
				dest_reg     <= rt_f;
			end
		end
	end

	// External controller request, held until acknowledged
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			ext_req       <= 1'b0;
			ext_we        <= 1'b0;
			ext_uncached  <= 1'b0;
			ext_addr      <= '0;
			ext_id        <= '0;
			ext_wdata     <= '0;
			eff_loc       <= '0;
			prot_is_store <= 1'b0;
		end else if (clock_enable) begin
			if (take && (is_in || is_out)) begin
				eff_loc       <= loc;
				prot_is_store <= is_out;
			end
			if (ext_take) begin
				ext_req      <= 1'b1;
				ext_we       <= is_out;
				ext_uncached <= 1'b1;
				ext_addr     <= real_addr_in;
				ext_id       <= target_unit_id;
				ext_wdata    <= is_out ? store_src_val : '0;
			end else if (ext_done) begin
				ext_req      <= 1'b0;
				ext_uncached <= 1'b0;
			end
		end
	end

	// Barrier holds later memory accesses while draining
	always_ff @(posedge clock or posedge reset) begin
		if (reset) mem_hold <= 1'b0;
		else if (clock_enable) mem_hold <= (state_next == ST_DRAIN);
	end

	// Writeback, condition field and exception pulses; barrier drives none
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			wb_en       <= 1'b0;
			wb_idx      <= '0;
			wb_data     <= '0;
			cr0_we      <= 1'b0;
			cr0_val     <= '0;
			carry_we    <= 1'b0;
			illegal_exc <= 1'b0;
		end else if (clock_enable) begin
			wb_en       <= alu_take || (ext_done && !is_store_reg);
			cr0_we      <= alu_take && rc;
			carry_we    <= alu_take && is_sw;
			illegal_exc <= ill_take;
			if (alu_take) begin
				wb_idx  <= ra_f;
				wb_data <= alu_res;
				cr0_val <= cr_flags(alu_res, summary_ovf);
			end else if (ext_done && !is_store_reg) begin
				wb_idx  <= dest_reg;
				wb_data <= {{(XLEN-32){1'b0}}, ext_rdata};
			end
		end
	end

	// Ready flag and interrupt block; set wins over clear
	logic [2:0] irq_mask_reg;
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			issue_ready  <= 1'b1;
			irq_status   <= '0;
			irq_mask_reg <= '0;
			irq          <= 1'b0;
		end else if (clock_enable) begin
			issue_ready  <= (state_next == ST_IDLE);
			irq_status   <= evt | (irq_status & ~(irq_clear_wr ? irq_clear_data : 3'h0));
			if (irq_mask_wr) irq_mask_reg <= irq_mask_data;
			irq <= |((evt | (irq_status & ~(irq_clear_wr ? irq_clear_data : 3'h0)))
				& (irq_mask_wr ? irq_mask_data : irq_mask_reg));
		end
	end
endmodule : ext_ctl_io_and_logic_ops

// >>> design/xops_defs.svh
// Constants for the external-control, barrier, sign-extend and xnor execute unit.
// Assumes inclusion by bare name; definitions only.
`ifndef XOPS_DEFS_SVH
`define XOPS_DEFS_SVH
`define PRIMARY_OP          6'h1f
`define XO_EXT_IN           10'h136
`define XO_EXT_OUT          10'h1b6
`define XO_BARRIER          10'h356
`define XO_SEXT_WORD        10'h3da
`define XO_XNOR             10'h11c
`define XO_SEXT_BYTE        10'h3ba
`define OPC_MSB             31
`define OPC_LSB             26
`define RT_MSB              25
`define RT_LSB              21
`define RA_MSB              20
`define RA_LSB              16
`define RB_MSB              15
`define RB_LSB              11
`define XO_MSB              10
`define XO_LSB              1
`define RC_POS              0
`define WORD_ALIGN_BITS     2
`endif

// >>> design/xops_pkg.sv
// Types shared by the execute unit and its surroundings.
// Assumes xops_defs.svh supplies the numeric constants.
package xops_pkg;
	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_EXT   = 4'b0010,
		ST_DRAIN = 4'b0100,
		ST_DONE  = 4'b1000
	} exec_state_t;
	typedef logic [4:0] gpr_idx_t;
endpackage : xops_pkg

// >>> test/ext_ctl_partner.sv
// External controller model facing the execute unit's controller port.
// Assumes one request at a time, held until the acknowledge has been seen.
`timescale 1ns/1ps
module ext_ctl_partner (
	input  wire logic        clock,
	input  wire logic        reset,
	input  wire logic        ext_req,
	input  wire logic [63:0] ext_addr,
	output logic             ext_ack,
	output logic [31:0]      ext_rdata
);
	int cnt;  // Cycles the open request has waited
	int dly;  // Wait before answering, rotates 0 to 3
	// Answer after a varying delay; data toggles whenever no answer is given
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			ext_ack   <= 1'b0;
			ext_rdata <= 32'h0;
			cnt       <= 0;
			dly       <= 0;
		end else if (ext_req && !ext_ack && cnt >= dly) begin
			ext_ack   <= 1'b1;
			ext_rdata <= ext_addr[31:0] ^ 32'h5a5aa5a5;
			cnt       <= 0;
			dly       <= (dly + 1) % 4;
		end else begin
			ext_ack   <= 1'b0;
			ext_rdata <= ~ext_rdata;
			cnt       <= ext_req ? cnt + 1 : 0;
		end
	end
endmodule : ext_ctl_partner

// >>> test/ext_ctl_io_and_logic_ops_monitor.sv
// Checker for the execute unit, bound to its top module.
// Assumes the single core clock and the active-high reset.
`timescale 1ns/1ps
`include "xops_defs.svh"
module ext_ctl_monitor #(parameter int XLEN = 64) (
	input wire logic clock, reset, clock_enable, issue_valid, issue_ready, xtrnl_accss_flag, summary_ovf,
	input wire logic ext_ack, ext_req, ext_we, ext_uncached, prot_is_store, mem_hold, wb_en, cr0_we, carry_we,
	input wire logic [31:0] instr_word, ext_rdata,
	input wire logic [5:0] target_unit_id, ext_id,
	input wire logic [3:0] cr0_val,
	input wire logic [XLEN-1:0] index_val, store_src_val, real_addr_in, eff_loc, ext_addr, ext_wdata, wb_data
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	// Instruction of the given kind taken this cycle
	sequence s_take(logic [9:0] x);
		clock_enable && issue_valid && issue_ready && instr_word[31:26] == `PRIMARY_OP && instr_word[10:1] == x;
	endsequence
	sequence s_ack_load;
		ext_req && !ext_we && ext_ack;
	endsequence
	property p_loc;
		s_take(`XO_EXT_IN) ##0 (xtrnl_accss_flag && instr_word[20:16] == 5'h0) |=> eff_loc == $past(index_val);
	endproperty
	a_loc: assert property (p_loc) else $error("location not index alone");
	property p_in;
		s_take(`XO_EXT_IN) ##0 xtrnl_accss_flag |=> ext_req && ext_uncached && !ext_we && !prot_is_store
			&& ext_id == $past(target_unit_id) && ext_addr == $past(real_addr_in);
	endproperty
	a_in: assert property (p_in) else $error("load request wrong");
	property p_out;
		s_take(`XO_EXT_OUT) ##0 xtrnl_accss_flag |=> ext_req && ext_we && prot_is_store && ext_wdata == $past(store_src_val);
	endproperty
	a_out: assert property (p_out) else $error("store request wrong");
	property p_load;
		s_ack_load |=> wb_en && wb_data[31:0] == $past(ext_rdata);
	endproperty
	a_load: assert property (p_load) else $error("returned word not written");
	property p_xnor;
		s_take(`XO_XNOR) |=> wb_en && !carry_we && wb_data == ~($past(store_src_val) ^ $past(index_val));
	endproperty
	a_xnor: assert property (p_xnor) else $error("xnor result wrong");
	property p_sextw;
		s_take(`XO_SEXT_WORD) ##0 (XLEN == 64) |=> carry_we && wb_data == XLEN'($signed($past(store_src_val[31:0])));
	endproperty
	a_sextw: assert property (p_sextw) else $error("word extend wrong");
	property p_sextb;
		s_take(`XO_SEXT_BYTE) |=> wb_en && wb_data == XLEN'($signed($past(store_src_val[7:0])));
	endproperty
	a_sextb: assert property (p_sextb) else $error("byte extend wrong");
	property p_bar;
		s_take(`XO_BARRIER) |=> mem_hold && !wb_en && !cr0_we;
	endproperty
	a_bar: assert property (p_bar) else $error("barrier effects wrong");
	property p_cr0;
		s_take(`XO_XNOR) ##0 instr_word[0] |=> cr0_we && cr0_val == {wb_data[XLEN-1],
			!wb_data[XLEN-1] && wb_data != 0, wb_data == 0, $past(summary_ovf)};
	endproperty
	a_cr0: assert property (p_cr0) else $error("condition field wrong");
endmodule : ext_ctl_monitor
bind ext_ctl_io_and_logic_ops ext_ctl_monitor #(.XLEN(XLEN)) mon (.clock(clock), .reset(reset),
	.clock_enable(clock_enable), .issue_valid(issue_valid), .issue_ready(issue_ready),
	.xtrnl_accss_flag(xtrnl_accss_flag), .summary_ovf(summary_ovf), .ext_ack(ext_ack), .ext_req(ext_req),
	.ext_we(ext_we), .ext_uncached(ext_uncached), .prot_is_store(prot_is_store), .mem_hold(mem_hold),
	.wb_en(wb_en), .cr0_we(cr0_we), .carry_we(carry_we), .instr_word(instr_word), .ext_rdata(ext_rdata),
	.target_unit_id(target_unit_id), .ext_id(ext_id), .cr0_val(cr0_val), .index_val(index_val),
	.store_src_val(store_src_val), .real_addr_in(real_addr_in), .eff_loc(eff_loc), .ext_addr(ext_addr),
	.ext_wdata(ext_wdata), .wb_data(wb_data));

// >>> test/ext_ctl_io_and_logic_ops_tb.sv
// Self-checking bench for the execute unit with a controller model.
// Assumes a 64-bit build and the defaults of the design's constants file.
`timescale 1ns/1ps
`include "xops_defs.svh"
module ext_ctl_io_and_logic_ops_tb;
	logic clock, reset, issue_valid, flag, ci_pending, clr_wr, msk_wr, so, ready, prot, req, we, unc, hold;
	logic wb_en, cr0_we, carry_we, illegal, irq, ack;
	logic ce;     // Clock enable driven by the bench
	int n_loads;  // Write-backs seen during the last settle
	logic [31:0] instr_word, rdata;
	logic [63:0] base, idx, src, raddr, loc, addr, wdata, wb_data, s, i, e;
	logic [5:0] tid, ext_id;
	logic [4:0] wb_idx;
	logic [3:0] cr0_val;
	logic [2:0] clr_d, msk_d, status;
	logic [9:0] xo;
	integer seed = 32'h928b;
	int fail_count, n_checks;
	ext_ctl_io_and_logic_ops #(.XLEN(64)) dut (.clock(clock), .reset(reset), .clock_enable(ce),
		.issue_valid(issue_valid), .instr_word(instr_word), .base_val(base), .index_val(idx),
		.store_src_val(src), .xtrnl_accss_flag(flag), .target_unit_id(tid), .summary_ovf(so),
		.real_addr_in(raddr), .ext_ack(ack), .ext_rdata(rdata), .ci_pending(ci_pending), .irq_clear_wr(clr_wr),
		.irq_clear_data(clr_d), .irq_mask_wr(msk_wr), .irq_mask_data(msk_d), .issue_ready(ready),
		.eff_loc(loc), .prot_is_store(prot), .ext_req(req), .ext_we(we), .ext_uncached(unc), .ext_addr(addr),
		.ext_id(ext_id), .ext_wdata(wdata), .mem_hold(hold), .wb_en(wb_en), .wb_idx(wb_idx), .wb_data(wb_data),
		.cr0_we(cr0_we), .cr0_val(cr0_val), .carry_we(carry_we), .illegal_exc(illegal), .irq_status(status),
		.irq(irq));
	ext_ctl_partner far_end (.clock(clock), .reset(reset), .ext_req(req), .ext_addr(addr), .ext_ack(ack),
		.ext_rdata(rdata));
	initial begin clock = 0; forever #25 clock = ~clock; end
	task check(input string what, input logic [63:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin fail_count++; $display("CHECK FAILED %s exp %h seen %h", what, exp, seen); end
	endtask : check
	task close_out;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : close_out
	// Offer one instruction with its operands; returns just after the taking edge
	task drive(input [9:0] x, input bit rc, input [4:0] ra_f, input [63:0] sv, iv);
		@(posedge clock);
		instr_word <= {`PRIMARY_OP, 5'd3, ra_f, 5'd5, x, rc};
		src <= sv; idx <= iv; so <= 1'($random(seed)); issue_valid <= 1'b1;
		@(posedge clock);
		issue_valid <= 1'b0;
		#1;
	endtask : drive
	// Wait for the unit to return to idle, checking any load write-back
	task settle;
		n_loads = 0;
		for (int n = 0; n < 20 && !ready; n++) begin
			@(posedge clock); #1;
			if (wb_en) begin
				n_loads++;
				check("load word", wb_data, {32'h0, raddr[31:0] ^ 32'h5a5aa5a5});
			end
		end
		check("idle again", ready, 1'b1);
	endtask : settle
	task irq_write(input bit clr, input [2:0] d);
		@(posedge clock); clr_wr <= clr; msk_wr <= !clr; clr_d <= d; msk_d <= d;
		@(posedge clock); clr_wr <= 1'b0; msk_wr <= 1'b0; #1;
	endtask : irq_write
	initial begin
		{issue_valid, flag, ci_pending, clr_wr, msk_wr, so, clr_d, msk_d, tid} = '0;
		ce = 1'b1;
		{instr_word, base, idx, src, raddr} = '0;
		reset = 1'b1;
		repeat (6) @(posedge clock);
		reset <= 1'b0;
		// Logic ops, both record forms, zero and random operands
		for (int k = 0; k < 12; k++) begin
			xo = (k % 3 == 0) ? `XO_XNOR : (k % 3 == 1) ? `XO_SEXT_BYTE : `XO_SEXT_WORD;
			s = (k < 3) ? 64'h0 : {$random(seed), $random(seed)};
			i = {$random(seed), $random(seed)};
			drive(xo, k % 2, 5'(k), s, i);
			e = (k % 3 == 0) ? ~(s ^ i) : (k % 3 == 1) ? {{56{s[7]}}, s[7:0]} : {{32{s[31]}}, s[31:0]};
			check("result", wb_data, e);
			check("write", {wb_en, wb_idx}, {1'b1, 5'(k)});
			check("carry", carry_we, k % 3 == 2);
			check("cr0 write", cr0_we, k % 2);
			check("no illegal", illegal, 1'b0);
			if (k % 2) check("cr0", cr0_val, {e[63], !e[63] && e != 0, e == 0, so});
		end
		// External in/out with enable off and on, base field zero and not
		for (int k = 0; k < 8; k++) begin
			s = {$random(seed), $random(seed)};
			i = {$random(seed), $random(seed)} & ~64'h3;
			base <= {$random(seed), $random(seed)} & ~64'h3;
			flag <= k[1]; tid <= 6'(k + 9);
			#1 e = k[2] ? base + i : i;
			raddr <= e ^ 64'h1000;
			drive(k[0] ? `XO_EXT_OUT : `XO_EXT_IN, 1'b0, k[2] ? 5'd4 : 5'd0, s, i);
			check("request", req, k[1]);
			if (k[1]) begin
				check("location", loc, e);
				check("addr id", {addr, ext_id}, {e ^ 64'h1000, 6'(k + 9)});
				check("kind", {we, prot, unc}, {k[0], k[0], 1'b1});
				if (k[0]) check("store data", wdata, s);
			end
			settle;
			check("load count", n_loads, (k[1] && !k[0]) ? 1 : 0);
		end
		// Clock enable low: an offered xnor must not be taken
		ce <= 1'b0;
		drive(`XO_XNOR, 1'b1, 5'd7, 64'h0, 64'h0);
		check("frozen", {wb_en, cr0_we, ready}, 3'b001);
		ce <= 1'b1;
		// Barrier with an open cache-inhibited access, then with none
		for (int p = 1; p >= 0; p--) begin
			ci_pending <= p[0];
			drive(`XO_BARRIER, 1'b0, 5'd0, 64'h0, 64'h0);
			check("hold", {hold, wb_en, cr0_we}, 3'b100);
			repeat (3) @(posedge clock);
			#1 check("still held", hold, p);
			ci_pending <= 1'b0;
			settle;
			check("barrier writes", n_loads, 0);
		end
		// Interrupts: events seen, masked, unmasked, cleared
		check("events", status, 3'b011);
		irq_write(1'b0, 3'h2); check("irq on", irq, 1'b1);
		irq_write(1'b1, 3'h2); check("irq masked", irq, 1'b0);
		irq_write(1'b0, 3'h7); check("irq again", irq, 1'b1);
		irq_write(1'b1, 3'h7); check("cleared", {irq, status}, 4'h0);
		$display("tests done");
		close_out;
	end
	initial begin
		repeat (3000) @(posedge clock);
		fail_count++;
		close_out;
	end
endmodule : ext_ctl_io_and_logic_ops_tb
